// [rtl/dac_link_pkg.sv]
// Shared constants for the serial code loader and its three-wire master.
package dac_link_pkg;
   // Code and frame geometry.
   localparam int CODE_W = 16;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [CODE_W-1:0] DAC_RESET = 16'h0000;
   // The output fraction is the code over two to this power.
   localparam int FRAC_SHIFT = 16;

   // System clock and link timing.
   localparam int SYS_PERIOD_NS = 4;
   localparam int SCLK_MAX_MHZ = 50;
   localparam int SCLK_MIN_HALF_NS = 1000 / (2 * SCLK_MAX_MHZ);
   localparam int CS_GAP_NS = 20;
   localparam int CS_HOLD_NS = 10;
   // Least times round up to whole system cycles.
   localparam int SCLK_HALF_CYC =
      (SCLK_MIN_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CS_GAP_CYC =
      (CS_GAP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CS_HOLD_CYC =
      (CS_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

   // Master register map, APB byte addresses.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CODE = 8'h00;
   localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h08;
   localparam logic [7:0] CTRL_RESET = 8'(SCLK_HALF_CYC);
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_CODE_LSB = 16;
endpackage

// [rtl/dac_link_if.sv]
// Three-wire write link between the serial master and the code loader.
`timescale 1ns/100ps
`default_nettype none
interface dac_link_if;
   logic cs_n;
   logic sclk;
   logic serial_in_alt;

   // The master drives all three wires.
   modport host (
      output cs_n,
      output sclk,
      output serial_in_alt
   );

   // The loader only listens.
   modport device (
      input cs_n,
      input sclk,
      input serial_in_alt
   );
endinterface
`default_nettype wire

// [rtl/serial_dac_code_loader.sv]
// Serial input logic of a 16-bit multiplying converter: shift and load.
`timescale 1ns/100ps
`default_nettype none
module serial_dac_code_loader #(
   parameter int CODE_W = dac_link_pkg::CODE_W
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Three-wire link from the master.
   dac_link_if.device link,
   // Reference level for the output fraction.
   input wire logic signed [CODE_W-1:0] ref_level,
   // Converter register and its scaled output.
   output logic [CODE_W-1:0] dac_input_code,
   output logic signed [CODE_W:0] ladder_current_out,
   // Frame status.
   output logic code_loaded,
   output logic word_done,
   output logic frame_active,
   output logic overrun,
   output logic short_frame,
   output logic [dac_link_pkg::CNT_W-1:0] bit_count
);
   import dac_link_pkg::*;

   localparam int IN_W = 3;
   localparam int I_CLK = 0;
   localparam int I_DAT = 1;
   localparam int I_CS = 2;
   // Idle link: select high, clock and data low.
   localparam logic [IN_W-1:0] IN_IDLE = 3'h4;
   localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_BITS - 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(FRAME_BITS);

   // Scales the code into a signed fraction of the reference, inverted.
   function automatic logic signed [CODE_W:0] scale_code(
      input logic signed [CODE_W-1:0] ref_in,
      input logic [CODE_W-1:0] code
   );
      logic signed [2*CODE_W+1:0] prod;
      logic signed [2*CODE_W+1:0] frac;
      prod = (2*CODE_W+2)'(ref_in) * $signed({2'b00, code});
      frac = prod >>> FRAC_SHIFT;
      scale_code = -frac[CODE_W:0];
   endfunction

   // Synchroniser and edge history.
   logic [IN_W-1:0] sync_a;
   logic [IN_W-1:0] sync_b;
   logic [IN_W-1:0] hist;
   logic [IN_W-1:0] next_sync_a;
   logic [IN_W-1:0] next_sync_b;
   logic [IN_W-1:0] next_hist;
   // Shift register and its bit counter.
   logic [CODE_W-1:0] shreg;
   logic [CODE_W-1:0] next_shreg;
   logic [CNT_W-1:0] next_bit_count;
   logic [CNT_W-1:0] base;
   // Frame flags.
   logic next_word_done;
   logic next_overrun;
   logic next_short_frame;
   // Converter register and its scaled output.
   logic [CODE_W-1:0] next_dac_input_code;
   logic signed [CODE_W:0] next_ladder_current_out;
   logic next_code_loaded;
   // Decoded link events.
   logic clk_rise;
   logic cs_fall;
   logic cs_rise;
   logic cs_low;
   logic bit_taken;

   // All three wires come from another domain and pass two flip-flops;
   // a third stage keeps the history that edges are found against.
   always_comb begin
      next_sync_a = {link.cs_n, link.serial_in_alt, link.sclk};
      next_sync_b = sync_a;
      next_hist = sync_b;
   end

   // Registers of the synchroniser; they reset to the idle link so that
   // no false edge follows reset.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= IN_IDLE;
         sync_b <= IN_IDLE;
         hist <= IN_IDLE;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         hist <= next_hist;
      end
   end

   // Edges are found on the second stage against its own history.
   assign clk_rise = sync_b[I_CLK] & ~hist[I_CLK];
   assign cs_fall = hist[I_CS] & ~sync_b[I_CS];
   assign cs_rise = sync_b[I_CS] & ~hist[I_CS];
   assign cs_low = ~sync_b[I_CS];
   assign frame_active = cs_low;
   // A bit is taken only inside a frame; with select high the shift register and count hold.
   assign bit_taken = cs_low & clk_rise;

   // A clock edge in the very cycle of the select fall counts as bit one.
   assign base = cs_fall ? '0 : bit_count;

   // Next state of the shift register and its bit counter.
   always_comb begin
      next_shreg = shreg;
      next_bit_count = bit_count;
      if (cs_fall) begin
         // A new write sequence forgets the previous frame's count.
         next_bit_count = '0;
      end
      if (bit_taken) begin
         // Earlier bits move up, so the first bit ends in the top place.
         next_shreg = {shreg[CODE_W-2:0], sync_b[I_DAT]};
         // The count stops at a full word; later bits still shift.
         if (base != FULL) begin
            next_bit_count = base + 1'b1;
         end else begin
            next_bit_count = FULL;
         end
      end
   end

   // Registers of the shift register and its bit counter.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         shreg <= DAC_RESET;
         bit_count <= '0;
      end else begin
         shreg <= next_shreg;
         bit_count <= next_bit_count;
      end
   end

   // Next values of the frame flags; a set in the cycle of a clear wins.
   always_comb begin
      next_word_done = 1'b0;
      next_overrun = overrun;
      next_short_frame = short_frame;
      if (cs_fall) begin
         next_overrun = 1'b0;
         next_short_frame = 1'b0;
      end
      if (bit_taken && base == LAST_BIT) begin
         // The sixteenth rise completes the word.
         next_word_done = 1'b1;
      end
      if (bit_taken && base == FULL) begin
         // Extra clocks keep shifting; only the last 16 bits remain.
         next_overrun = 1'b1;
      end
      if (cs_rise) begin
         // A frame closed before its sixteenth rise is flagged.
         next_short_frame = (bit_count != FULL);
      end
   end

   // Registers of the frame flags.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         word_done <= 1'b0;
         overrun <= 1'b0;
         short_frame <= 1'b0;
      end else begin
         word_done <= next_word_done;
         overrun <= next_overrun;
         short_frame <= next_short_frame;
      end
   end

   // Next values of the converter register and its scaled output.
   always_comb begin
      // Shifting alone never touches the converter register.
      next_dac_input_code = dac_input_code;
      next_code_loaded = 1'b0;
      if (cs_rise) begin
         // Transfer on the select rise, whatever the clock level.
         next_dac_input_code = shreg;
         next_code_loaded = 1'b1;
      end
      next_ladder_current_out = scale_code(ref_level, dac_input_code);
   end

   // Registers of the converter register and its output.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dac_input_code <= DAC_RESET;
         ladder_current_out <= '0;
         code_loaded <= 1'b0;
      end else begin
         dac_input_code <= next_dac_input_code;
         ladder_current_out <= next_ladder_current_out;
         code_loaded <= next_code_loaded;
      end
   end
endmodule
`default_nettype wire

// [rtl/serial_dac_master.sv]
// APB-controlled three-wire master that writes codes to the loader.
`timescale 1ns/100ps
`default_nettype none
module serial_dac_master #(
   parameter int CODE_W = dac_link_pkg::CODE_W
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // APB slave port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dac_link_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Three-wire link to the loader.
   dac_link_if.host link
);
   import dac_link_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE, ST_LOW, ST_HIGH, ST_HOLD, ST_GAP
   } link_state_e;

   localparam logic [7:0] HALF_MIN = 8'(SCLK_HALF_CYC);
   localparam logic [7:0] HOLD_CNT = 8'(CS_HOLD_CYC - 1);
   localparam logic [7:0] GAP_CNT = 8'(CS_GAP_CYC - 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(FRAME_BITS - 1);

   link_state_e state;
   link_state_e next_state;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [7:0] half;
   logic [7:0] next_half;
   logic [CNT_W-1:0] bits;
   logic [CNT_W-1:0] next_bits;
   logic [CODE_W-1:0] shreg;
   logic [CODE_W-1:0] next_shreg;
   logic [CODE_W-1:0] last_code;
   logic [CODE_W-1:0] next_last_code;
   logic cs_n;
   logic next_cs_n;
   logic sclk;
   logic next_sclk;
   logic sdo;
   logic next_sdo;
   logic [31:0] next_prdata;
   logic access;
   logic mapped;
   logic busy;
   logic start;

   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.serial_in_alt = sdo;

   // APB decode; every access completes in its first access cycle.
   assign busy = (state != ST_IDLE);
   assign access = psel & penable;
   assign mapped = (paddr == REG_CODE) | (paddr == REG_CTRL) |
                   (paddr == REG_STATUS);
   assign pready = 1'b1;
   assign pslverr = access & (~mapped | (pwrite & (paddr == REG_CODE) & busy));
   assign start = access & pwrite & (paddr == REG_CODE) & ~busy;

   // Register file and link sequencer next values.
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_half = half;
      next_bits = bits;
      next_shreg = shreg;
      next_last_code = last_code;
      next_cs_n = cs_n;
      next_sclk = sclk;
      next_sdo = sdo;
      next_prdata = prdata;
      // Read data is formed in the setup cycle so it comes from a flop.
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            REG_CTRL: next_prdata = {24'h000000, half};
            REG_STATUS: begin
               next_prdata = '0;
               next_prdata[STATUS_BUSY_BIT] = busy;
               next_prdata[STATUS_CODE_LSB +: CODE_W] = last_code;
            end
            default: next_prdata = '0;
         endcase
      end
      // Half periods below the minimum are raised to keep under 50 MHz.
      if (access && pwrite && paddr == REG_CTRL) begin
         next_half = (pwdata[7:0] < HALF_MIN) ? HALF_MIN : pwdata[7:0];
      end
      unique case (state)
         ST_IDLE: begin
            if (start) begin
               // Select falls with the top bit already on the data wire.
               next_shreg = pwdata[CODE_W-1:0];
               next_last_code = pwdata[CODE_W-1:0];
               next_sdo = pwdata[CODE_W-1];
               next_cs_n = 1'b0;
               next_sclk = 1'b0;
               next_cnt = half - 1'b1;
               next_bits = LAST;
               next_state = ST_LOW;
            end
         end
         ST_LOW: begin
            if (cnt == '0) begin
               next_sclk = 1'b1;
               next_cnt = half - 1'b1;
               next_state = ST_HIGH;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_HIGH: begin
            if (cnt == '0) begin
               next_sclk = 1'b0;
               if (bits == '0) begin
                  // Sixteen rises sent; hold select before raising it.
                  next_cnt = HOLD_CNT;
                  next_state = ST_HOLD;
               end else begin
                  next_bits = bits - 1'b1;
                  next_shreg = {shreg[CODE_W-2:0], 1'b0};
                  next_sdo = shreg[CODE_W-2];
                  next_cnt = half - 1'b1;
                  next_state = ST_LOW;
               end
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_HOLD: begin
            if (cnt == '0) begin
               // The rise of select is what loads the converter register.
               next_cs_n = 1'b1;
               next_cnt = GAP_CNT;
               next_state = ST_GAP;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
         ST_GAP: begin
            if (cnt == '0) begin
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
      endcase
   end

   // Registers of the sequencer and register file.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cnt <= '0;
         half <= CTRL_RESET;
         bits <= '0;
         shreg <= '0;
         last_code <= '0;
         cs_n <= 1'b1;
         sclk <= 1'b0;
         sdo <= 1'b0;
         prdata <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         half <= next_half;
         bits <= next_bits;
         shreg <= next_shreg;
         last_code <= next_last_code;
         cs_n <= next_cs_n;
         sclk <= next_sclk;
         sdo <= next_sdo;
         prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

// [testbench/dac_link_monitor.sv]
// Wire-level checks on the three-wire link between the two ends.
`timescale 1ns/100ps
`default_nettype none
module dac_link_monitor (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Link wires.
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic serial_in_alt
);
   logic sclk_q;
   logic [4:0] rises;
   logic [4:0] next_rises;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // Counts clock rises in the current frame; it stops short of wrapping.
   always_comb begin
      next_rises = rises;
      if (cs_n) begin
         next_rises = 5'h00;
      end else if (sclk && !sclk_q && rises != 5'h1f) begin
         next_rises = rises + 5'h01;
      end
   end

   // Registers the rise count and the last clock level.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q <= 1'b0;
         rises <= 5'h00;
      end else begin
         sclk_q <= sclk;
         rises <= next_rises;
      end
   end

   // Least widths, in system cycles, of clock phases and the select gap.
   sequence s_low3;
      !sclk [*3];
   endsequence
   sequence s_high3;
      sclk [*3];
   endsequence
   sequence s_gap5;
      cs_n [*5];
   endsequence

   chk_gap_held: assert property ($rose(cs_n) |-> s_gap5)
      else $error("select gap too short");
   chk_clock_high: assert property ($rose(sclk) |-> s_high3)
      else $error("serial clock high too short");
   chk_clock_low: assert property ($fell(sclk) |-> s_low3)
      else $error("serial clock low too short");
   chk_start_setup: assert property ($fell(cs_n) |-> s_low3)
      else $error("clock rose too soon after select fell");
   chk_idle_still: assert property (cs_n |-> !sclk)
      else $error("serial clock moved outside a frame");
   chk_word_count: assert property ($rose(cs_n) |-> rises == 5'h10)
      else $error("frame did not hold sixteen clock rises");
   chk_no_extra: assert property (!cs_n |-> rises <= 5'h10)
      else $error("more than sixteen rises in a frame");
   chk_data_steady: assert property (
      !cs_n && sclk |-> $stable(serial_in_alt))
      else $error("data moved while clock high");
   chk_frame_bound: assert property (
      $fell(cs_n) |-> ##[1:1000] $rose(cs_n))
      else $error("select not raised after the frame");
endmodule
`default_nettype wire

// [testbench/test_serial_dac_code_loader.sv]
// Bench joining the serial master and the code loader over the link.
`timescale 1ns/100ps
`default_nettype none
module test_serial_dac_code_loader;
   import dac_link_pkg::*;
   logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdata;
   logic pready, pslverr, perr, code_loaded, word_done, frame_active;
   logic overrun, short_frame, tb_sclk_q = 0;
   logic signed [15:0] ref_level = 0;
   logic [15:0] dac_input_code, wire_word = 0, code_q = 0;
   logic signed [16:0] ladder_current_out;
   logic [4:0] bit_count;
   int miscompares = 0, n_compared = 0, cycles = 0, moved = 0;
   int n_done = 0, n_load = 0, n_frames = 0, i;
   logic [15:0] codes [4] = '{16'ha5c3, 16'h0000, 16'hffff, 16'h8001};
   logic [15:0] refs [4] = '{16'h4000, 16'h7fff, 16'h8000, 16'hc000};

   dac_link_if link_if ();
   serial_dac_master serial_dac_master_inst (.clk_sys(clk_sys),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_if.host));
   serial_dac_code_loader serial_dac_code_loader_inst (.clk_sys(clk_sys),
      .rst_b(rst_b), .link(link_if.device), .ref_level(ref_level),
      .dac_input_code(dac_input_code), .code_loaded(code_loaded),
      .ladder_current_out(ladder_current_out), .word_done(word_done),
      .frame_active(frame_active), .overrun(overrun),
      .short_frame(short_frame), .bit_count(bit_count));
   dac_link_monitor dac_link_monitor_inst (.clk_sys(clk_sys),
      .rst_b(rst_b), .cs_n(link_if.cs_n), .sclk(link_if.sclk),
      .serial_in_alt(link_if.serial_in_alt));

   // Makes the 250 MHz system clock.
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   // Rebuilds the word off the wire, counts pulses, cuts a hang short.
   always @(posedge clk_sys) begin
      tb_sclk_q <= link_if.sclk;
      code_q <= dac_input_code;
      if (!link_if.cs_n && link_if.sclk && !tb_sclk_q) begin
         wire_word <= {wire_word[14:0], link_if.serial_in_alt};
      end
      if (!link_if.cs_n && dac_input_code !== code_q) moved++;
      if (word_done === 1'b1) n_done++;
      if (code_loaded === 1'b1) n_load++;
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         test_done();
      end
   end

   // Compares a seen value with the expected one.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // One APB transfer; read data and error are taken with pready high.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Waits for the master to go idle, then checks the loaded code.
   task finish(input logic [15:0] c);
      logic signed [33:0] p;
      for (int k = 0; k < 400; k++) begin
         apb(1'b0, REG_STATUS, 32'h0);
         if (rdata[STATUS_BUSY_BIT] === 1'b0) break;
      end
      repeat (8) @(posedge clk_sys);
      p = $signed(ref_level) * $signed({1'b0, c});
      n_frames++;
      chk(rdata, {c, 16'h0000});
      chk(wire_word, c);
      chk(dac_input_code, c);
      chk(frame_active, 1'b0);
      chk(ladder_current_out, 17'(-(p >>> 16)));
      chk(bit_count, 5'h10);
      chk({overrun, short_frame}, 2'b00);
   endtask

   // Sets the reference and sends one code.
   task send(input logic [15:0] c, input logic [15:0] r);
      ref_level <= r;
      apb(1'b1, REG_CODE, {16'h0000, c});
      chk(perr, 1'b0);
      finish(c);
   endtask

   // Closing report.
   task test_done();
      $display("miscompares %0d n_compared %0d", miscompares, n_compared);
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      chk(dac_input_code, DAC_RESET);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rdata, 32'(CTRL_RESET));
      for (i = 0; i < 4; i++) send(codes[i], refs[i]);
      apb(1'b1, REG_CODE, 32'h1234);
      apb(1'b1, REG_CODE, 32'h00ff);
      chk(perr, 1'b1);
      finish(16'h1234);
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rdata, 32'h3);
      apb(1'b1, REG_CTRL, 32'h5);
      send(16'h6e19, 16'h2000);
      apb(1'b0, 8'h0c, 32'h0);
      chk(perr, 1'b1);
      chk(rdata, 32'h0);
      chk(moved, 0);
      chk(n_done, n_frames);
      chk(n_load, n_frames);
      test_done();
   end
endmodule
`default_nettype wire
